// file: src/fbbse_exec.sv
// execution unit for flag branches, I/O bit ops, shifts, rotates and flag set/clear
`timescale 1ns/1ps
module fbbse_exec (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             busy
);

    ////////////////////////////////////////////////////////////////////////
    // state

    fbbse_pkg::fbbse_state_t state;
    fbbse_pkg::fbbse_cmd_t   cmd;
    logic [7:0]              operand;
    logic [7:0]              status;
    logic [15:0]             pc;
    logic [1:0]              lastCycles;
    logic [7:0]              ioMem [fbbse_pkg::IO_COUNT];

    logic                    busWrite;
    logic                    busRead;
    logic                    startCmd;
    logic                    ioHit;
    logic [1:0]              ioIndex;

    logic [7:0]              next_operand;
    logic [7:0]              next_status;
    logic [15:0]             next_pc;
    logic [7:0]              next_io;
    logic                    ioWrite;
    logic                    longOp;

    logic [7:0]              shRes;
    logic                    shCarry;
    logic                    isShift;
    logic                    brCond;
    logic                    isBranch;
    logic [15:0]             kExt;

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave

    // a write lands on the edge where ack is high, as the master samples it
    assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign busRead  = wb_cyc_i & wb_stb_i & ~wb_we_i;
    assign startCmd = busWrite & (wb_adr_i == fbbse_pkg::OFS_CTRL) & (state == fbbse_pkg::ST_IDLE);
    assign ioHit    = (wb_adr_i[7:4] == fbbse_pkg::OFS_IO_BASE[7:4]) & (wb_adr_i[1:0] == 2'h0);
    assign ioIndex  = wb_adr_i[3:2];
    assign busy     = (state != fbbse_pkg::ST_IDLE);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (busRead & ~wb_ack_o) begin
            wb_dat_o <= 32'h0000_0000;
            if (wb_adr_i == fbbse_pkg::OFS_CTRL) begin
                // read back in the same field layout that the command write uses
                wb_dat_o[fbbse_pkg::CTRL_OP_LSB +: 5]  <= cmd.op;
                wb_dat_o[fbbse_pkg::CTRL_BIT_LSB +: 3] <= cmd.bitSel;
                wb_dat_o[fbbse_pkg::CTRL_IO_LSB +: 2]  <= cmd.ioAddr;
                wb_dat_o[fbbse_pkg::CTRL_K_LSB +: 8]   <= cmd.offset;
                wb_dat_o[fbbse_pkg::CTRL_BUSY]         <= busy;
            end else if (wb_adr_i == fbbse_pkg::OFS_OPERAND) begin
                wb_dat_o[7:0] <= operand;
            end else if (wb_adr_i == fbbse_pkg::OFS_STATUS) begin
                wb_dat_o[7:0] <= status;
            end else if (wb_adr_i == fbbse_pkg::OFS_PC) begin
                wb_dat_o[15:0] <= pc;
            end else if (wb_adr_i == fbbse_pkg::OFS_CYCLES) begin
                wb_dat_o[1:0] <= lastCycles;
            end else if (ioHit) begin
                wb_dat_o[7:0] <= ioMem[ioIndex];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command capture

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd <= '{offset: 8'h00, ioAddr: 2'h0, bitSel: 3'h0, op: fbbse_pkg::OP_NOP};
        end else if (startCmd) begin
            cmd.op     <= fbbse_pkg::fbbse_op_t'(wb_dat_i[fbbse_pkg::CTRL_OP_LSB +: 5]);
            cmd.bitSel <= wb_dat_i[fbbse_pkg::CTRL_BIT_LSB +: 3];
            cmd.ioAddr <= wb_dat_i[fbbse_pkg::CTRL_IO_LSB +: 2];
            cmd.offset <= wb_dat_i[fbbse_pkg::CTRL_K_LSB +: 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= fbbse_pkg::ST_IDLE;
        end else begin
            case (state)
                fbbse_pkg::ST_IDLE: begin
                    if (startCmd) begin
                        state <= fbbse_pkg::ST_EXEC;
                    end
                end
                fbbse_pkg::ST_EXEC: begin
                    state <= longOp ? fbbse_pkg::ST_EXTRA : fbbse_pkg::ST_IDLE;
                end
                fbbse_pkg::ST_EXTRA: begin
                    state <= fbbse_pkg::ST_IDLE;
                end
                default: begin
                    state <= fbbse_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lastCycles <= 2'h0;
        end else if (state == fbbse_pkg::ST_EXEC) begin
            lastCycles <= longOp ? fbbse_pkg::CYC_LONG : fbbse_pkg::CYC_SHORT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // branch condition and target

    assign kExt = {{8{cmd.offset[7]}}, cmd.offset};

    always_comb begin
        isBranch = 1'b1;
        brCond   = 1'b0;
        case (cmd.op)
            fbbse_pkg::OP_BR_XFER_CLR: brCond = ~status[fbbse_pkg::FLAG_XFER];
            fbbse_pkg::OP_BR_OVF_SET:  brCond = status[fbbse_pkg::FLAG_OVF];
            fbbse_pkg::OP_BR_OVF_CLR:  brCond = ~status[fbbse_pkg::FLAG_OVF];
            fbbse_pkg::OP_BR_GIE_SET:  brCond = status[fbbse_pkg::FLAG_GIE];
            fbbse_pkg::OP_BR_GIE_CLR:  brCond = ~status[fbbse_pkg::FLAG_GIE];
            default:                   isBranch = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // shifter

    always_comb begin
        isShift = 1'b1;
        shRes   = operand;
        shCarry = status[fbbse_pkg::FLAG_CARRY];
        case (cmd.op)
            fbbse_pkg::OP_SHL_LOGICAL: begin
                shRes   = {operand[6:0], 1'b0};
                shCarry = operand[7];
            end
            fbbse_pkg::OP_SHR_LOGICAL: begin
                shRes   = {1'b0, operand[7:1]};
                shCarry = operand[0];
            end
            fbbse_pkg::OP_ROL_CARRY: begin
                shRes   = {operand[6:0], status[fbbse_pkg::FLAG_CARRY]};
                shCarry = operand[7];
            end
            fbbse_pkg::OP_ROR_CARRY: begin
                shRes   = {status[fbbse_pkg::FLAG_CARRY], operand[7:1]};
                shCarry = operand[0];
            end
            fbbse_pkg::OP_SHR_ARITH: begin
                shRes   = {operand[7], operand[7:1]};
                shCarry = operand[0];
            end
            default: begin
                isShift = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // result and flag selection

    always_comb begin
        next_operand = operand;
        next_status  = status;
        next_io      = ioMem[cmd.ioAddr];
        ioWrite      = 1'b0;
        longOp       = isBranch & brCond;
        next_pc      = isBranch & brCond ? pc + kExt + 16'h0001 : pc + 16'h0001;
        if (isShift) begin
            // overflow follows negative xor carry, the usual shifter convention
            next_operand                       = shRes;
            next_status[fbbse_pkg::FLAG_ZERO]  = (shRes == 8'h00);
            next_status[fbbse_pkg::FLAG_CARRY] = shCarry;
            next_status[fbbse_pkg::FLAG_NEG]   = shRes[7];
            next_status[fbbse_pkg::FLAG_OVF]   = shRes[7] ^ shCarry;
        end
        case (cmd.op)
            fbbse_pkg::OP_SET_IO_BIT: begin
                next_io[cmd.bitSel] = 1'b1;
                ioWrite             = 1'b1;
                longOp              = 1'b1;
            end
            fbbse_pkg::OP_CLR_IO_BIT: begin
                next_io[cmd.bitSel] = 1'b0;
                ioWrite             = 1'b1;
                longOp              = 1'b1;
            end
            fbbse_pkg::OP_NIBBLE_XCHG: begin
                next_operand = {operand[3:0], operand[7:4]};
            end
            fbbse_pkg::OP_STORE_BIT: begin
                next_status[fbbse_pkg::FLAG_XFER] = operand[cmd.bitSel];
            end
            fbbse_pkg::OP_LOAD_BIT: begin
                next_operand[cmd.bitSel] = status[fbbse_pkg::FLAG_XFER];
            end
            fbbse_pkg::OP_FLAG_SET: begin
                next_status[cmd.bitSel] = 1'b1;
            end
            fbbse_pkg::OP_FLAG_CLR: begin
                next_status[cmd.bitSel] = 1'b0;
            end
            fbbse_pkg::OP_SET_OVF:  next_status[fbbse_pkg::FLAG_OVF]  = 1'b1;
            fbbse_pkg::OP_CLR_OVF:  next_status[fbbse_pkg::FLAG_OVF]  = 1'b0;
            fbbse_pkg::OP_SET_SIGN: next_status[fbbse_pkg::FLAG_SIGN] = 1'b1;
            fbbse_pkg::OP_CLR_SIGN: next_status[fbbse_pkg::FLAG_SIGN] = 1'b0;
            fbbse_pkg::OP_SET_HALF: next_status[fbbse_pkg::FLAG_HALF] = 1'b1;
            fbbse_pkg::OP_CLR_HALF: next_status[fbbse_pkg::FLAG_HALF] = 1'b0;
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // architectural state, bus writes refused while an op is in flight

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            operand <= fbbse_pkg::RST_OPERAND;
        end else if (state == fbbse_pkg::ST_EXEC) begin
            operand <= next_operand;
        end else if (busWrite & ~busy & (wb_adr_i == fbbse_pkg::OFS_OPERAND)) begin
            operand <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status <= fbbse_pkg::RST_STATUS;
        end else if (state == fbbse_pkg::ST_EXEC) begin
            status <= next_status;
        end else if (busWrite & ~busy & (wb_adr_i == fbbse_pkg::OFS_STATUS)) begin
            status <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc <= fbbse_pkg::RST_PC;
        end else if (state == fbbse_pkg::ST_EXEC) begin
            pc <= next_pc;
        end else if (busWrite & ~busy & (wb_adr_i == fbbse_pkg::OFS_PC)) begin
            pc[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) begin
                pc[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // the read-modify-write of an I/O bit commits in the first cycle; the
    // second cycle only holds the unit busy so timing matches the core
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < fbbse_pkg::IO_COUNT; i++) begin
                ioMem[i] <= fbbse_pkg::RST_IO;
            end
        end else if ((state == fbbse_pkg::ST_EXEC) & ioWrite) begin
            ioMem[cmd.ioAddr] <= next_io;
        end else if (busWrite & ~busy & ioHit) begin
            ioMem[ioIndex] <= wb_dat_i[7:0];
        end
    end

endmodule : fbbse_exec

// file: src/fbbse_pkg.sv
// constants, types and field layout shared by the flag, branch, bit and shift execution unit
package fbbse_pkg;

    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_OPERAND = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_PC      = 8'h0c;
    localparam logic [7:0] OFS_CYCLES  = 8'h10;
    localparam logic [7:0] OFS_IO_BASE = 8'h20;
    localparam int         IO_COUNT    = 4;

    localparam logic [2:0] FLAG_CARRY = 3'h0;
    localparam logic [2:0] FLAG_ZERO  = 3'h1;
    localparam logic [2:0] FLAG_NEG   = 3'h2;
    localparam logic [2:0] FLAG_OVF   = 3'h3;
    localparam logic [2:0] FLAG_SIGN  = 3'h4;
    localparam logic [2:0] FLAG_HALF  = 3'h5;
    localparam logic [2:0] FLAG_XFER  = 3'h6;
    localparam logic [2:0] FLAG_GIE   = 3'h7;

    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_BIT_LSB = 8;
    localparam int CTRL_IO_LSB  = 12;
    localparam int CTRL_K_LSB   = 16;
    localparam int CTRL_BUSY    = 31;

    localparam logic [7:0]  RST_STATUS  = 8'h00;
    localparam logic [7:0]  RST_OPERAND = 8'h00;
    localparam logic [15:0] RST_PC      = 16'h0000;
    localparam logic [7:0]  RST_IO      = 8'h00;
    localparam logic [1:0]  CYC_SHORT   = 2'h1;
    localparam logic [1:0]  CYC_LONG    = 2'h2;

    typedef enum logic [4:0] {
        OP_NOP          = 5'h00,
        OP_BR_XFER_CLR  = 5'h01,
        OP_BR_OVF_SET   = 5'h02,
        OP_BR_OVF_CLR   = 5'h03,
        OP_BR_GIE_SET   = 5'h04,
        OP_BR_GIE_CLR   = 5'h05,
        OP_SET_IO_BIT   = 5'h06,
        OP_CLR_IO_BIT   = 5'h07,
        OP_SHL_LOGICAL  = 5'h08,
        OP_SHR_LOGICAL  = 5'h09,
        OP_ROL_CARRY    = 5'h0a,
        OP_ROR_CARRY    = 5'h0b,
        OP_SHR_ARITH    = 5'h0c,
        OP_NIBBLE_XCHG  = 5'h0d,
        OP_STORE_BIT    = 5'h0e,
        OP_LOAD_BIT     = 5'h0f,
        OP_FLAG_SET     = 5'h10,
        OP_FLAG_CLR     = 5'h11,
        OP_SET_OVF      = 5'h12,
        OP_CLR_OVF      = 5'h13,
        OP_SET_SIGN     = 5'h14,
        OP_CLR_SIGN     = 5'h15,
        OP_SET_HALF     = 5'h16,
        OP_CLR_HALF     = 5'h17
    } fbbse_op_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_EXTRA = 3'b100
    } fbbse_state_t;

    typedef struct packed {
        logic [7:0] offset;
        logic [1:0] ioAddr;
        logic [2:0] bitSel;
        fbbse_op_t  op;
    } fbbse_cmd_t;

endpackage : fbbse_pkg

// file: tb/fbbse_exec_properties.sv
// bus timing and busy-length checks on the execution unit's ports
`timescale 1ns/1ps
module fbbse_exec_properties (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic ctrlWr;
    assign ctrlWr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == fbbse_pkg::OFS_CTRL && !busy;
    sequence s_short;
        busy ##1 !busy;
    endsequence
    sequence s_long;
        busy ##1 busy ##1 !busy;
    endsequence
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_busy_cause: assert property ($rose(busy) |-> $past(ctrlWr))
        else $error("busy without a command write");
    a_busy_max_two: assert property (busy ##1 busy |=> !busy)
        else $error("busy longer than two cycles");
    a_io_ops_two: assert property (ctrlWr && wb_dat_i[4:1] == 4'h3 |=> s_long)
        else $error("bit op not two cycles");
    a_shift_ops_one: assert property (ctrlWr && wb_dat_i[4:0] inside {[5'h08:5'h17]} |=> s_short)
        else $error("single cycle op took wrong time");
    a_ctrl_read_busy: assert property (wb_ack_o && !wb_we_i && wb_adr_i == fbbse_pkg::OFS_CTRL |-> wb_dat_o[31] == $past(busy))
        else $error("busy bit in command read wrong");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h14 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
endmodule : fbbse_exec_properties

bind fbbse_exec fbbse_exec_properties i_props (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy(busy));

// file: tb/fbbse_wb_master.sv
// classic single-cycle bus master standing in for software
`timescale 1ns/1ps
module fbbse_wb_master (
    input  wire logic        clk,
    input  wire logic        ack,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [7:0]       adr,
    output logic [3:0]       sel,
    output logic [31:0]      dat
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h0;
    end

    // we, adr and dat are inverted on release so a slave cannot lean on stale values
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= ~w;
        adr <= ~a;
        dat <= ~d;
    endtask : access
endmodule : fbbse_wb_master

// file: tb/test_fbbse_exec.sv
// self-checking bench for the flag, branch, bit and shift execution unit
`timescale 1ns/1ps
module test_fbbse_exec;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        cyc, stb, we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
    logic [31:0] rdData;
    logic        ack;
    logic        busy;
    int          fail_count = 0;
    int          n_compared = 0;
    logic [31:0] rng = 32'h40ee4aee;
    logic [7:0]  expAdr[$];
    logic [31:0] expVal[$];

    fbbse_exec i_fbbse_exec (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdData), .wb_ack_o(ack), .busy(busy));
    fbbse_wb_master i_fbbse_wb_master (.clk(clk), .ack(ack), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .dat(dat));

    initial begin
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic check_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected read at %h: expected %h, seen %h", a, e, s);
        end
    endtask : check_read

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_fbbse_wb_master.access(1'b1, a, d);
    endtask : wr

    task automatic expect_read(input logic [7:0] a, input logic [31:0] v);
        expAdr.push_back(a);
        expVal.push_back(v);
        i_fbbse_wb_master.access(1'b0, a, 32'h0);
    endtask : expect_read

    // every register but I/O bytes 1 to 3 must be back at its reset value after any release of reset
    task automatic expect_reset_values();
        expect_read(fbbse_pkg::OFS_CTRL, 32'h0);
        expect_read(fbbse_pkg::OFS_OPERAND, {24'h0, fbbse_pkg::RST_OPERAND});
        expect_read(fbbse_pkg::OFS_STATUS, {24'h0, fbbse_pkg::RST_STATUS});
        expect_read(fbbse_pkg::OFS_PC, {16'h0, fbbse_pkg::RST_PC});
        expect_read(fbbse_pkg::OFS_CYCLES, 32'h0);
        expect_read(fbbse_pkg::OFS_IO_BASE, {24'h0, fbbse_pkg::RST_IO});
    endtask : expect_reset_values

    // results reach the bus in the ack cycle of a read and stay there until the next read
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && expVal.size() > 0) check_read(expAdr.pop_front(), expVal.pop_front(), rdData);
    end

    task automatic run_op(input logic [4:0] op);
        logic [31:0] v, w;
        logic [7:0]  opd, st, k, iv, r, s, nio, ioAdr;
        logic [2:0]  b;
        logic [1:0]  ix;
        logic [15:0] pc, npc;
        logic        c, tk, lng;
        v = rnd();
        w = rnd();
        {ix, b, k, st, opd} = v[28:0];
        pc = w[15:0];
        iv = w[23:16];
        ioAdr = fbbse_pkg::OFS_IO_BASE + {4'h0, ix, 2'b00};
        r = opd;
        s = st;
        c = st[0];
        tk = 1'b0;
        nio = iv;
        case (op)
            5'h01: tk = ~st[6];
            5'h02: tk = st[3];
            5'h03: tk = ~st[3];
            5'h04: tk = st[7];
            5'h05: tk = ~st[7];
            5'h06: nio[b] = 1'b1;
            5'h07: nio[b] = 1'b0;
            5'h08: {c, r} = {opd, 1'b0};
            5'h09: {r, c} = {1'b0, opd};
            5'h0a: {c, r} = {opd, st[0]};
            5'h0b: {r, c} = {st[0], opd};
            5'h0c: {r, c} = {opd[7], opd};
            5'h0d: r = {opd[3:0], opd[7:4]};
            5'h0e: s[6] = opd[b];
            5'h0f: r[b] = st[6];
            5'h10: s[b] = 1'b1;
            5'h11: s[b] = 1'b0;
            5'h12: s[3] = 1'b1;
            5'h13: s[3] = 1'b0;
            5'h14: s[4] = 1'b1;
            5'h15: s[4] = 1'b0;
            5'h16: s[5] = 1'b1;
            5'h17: s[5] = 1'b0;
            default: ;
        endcase
        if (op inside {[5'h08:5'h0c]}) s[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
        npc = pc + 16'h0001 + (tk ? {{8{k[7]}}, k} : 16'h0000);
        lng = tk || op == 5'h06 || op == 5'h07;
        wr(fbbse_pkg::OFS_OPERAND, {24'h0, opd});
        wr(fbbse_pkg::OFS_STATUS, {24'h0, st});
        wr(fbbse_pkg::OFS_PC, {16'h0, pc});
        wr(ioAdr, {24'h0, iv});
        wr(fbbse_pkg::OFS_CTRL, {8'h00, k, 2'b00, ix, 1'b0, b, 3'b000, op});
        expect_read(fbbse_pkg::OFS_CTRL, {lng, 7'h0, k, 2'b00, ix, 1'b0, b, 3'b000, op});
        expect_read(fbbse_pkg::OFS_OPERAND, {24'h0, r});
        expect_read(fbbse_pkg::OFS_STATUS, {24'h0, s});
        expect_read(fbbse_pkg::OFS_PC, {16'h0, npc});
        expect_read(fbbse_pkg::OFS_CYCLES, lng ? 32'h2 : 32'h1);
        expect_read(ioAdr, {24'h0, nio});
    endtask : run_op

    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        expect_reset_values();
        wr(8'h14, 32'hffffffff);
        expect_read(8'h14, 32'h0);
        for (int op = 0; op < 24; op++) begin
            repeat (6) run_op(op[4:0]);
        end
        // reset in mid-run must wipe the state left by the last command
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        expect_reset_values();
        repeat (3) @(posedge clk);
        stop_test();
    end

    // a full run needs about 5000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule : test_fbbse_exec
